// file: core/qec_map.vh
/*
 Register offsets, field positions and reset values of the quadrature
 encoder counter. Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
// Overview of operation
// - Single, double or quadruple decode by mode.
// - Track phase gives direction, count up/down.
// - Optional skip of first pulse after reversal.
// - Two 32-bit latches, internal or external strobe.
// - Strobes synchronised before capturing count.
// - Mode register writable and readable by host.
// - Capture by two pins or strobe register.
// - Enabled external strobe raises interrupt.
// - Strobes active high, routed latch or interrupt.
// - Split mode runs two 16-bit counters.
// - Single mode third input is index.
// - Single mode fourth input is fault.
// - Reference input may drive reference logic.
// - Compare, interrupt, reference logic on count.
`ifndef QEC_MAP_VH
`define QEC_MAP_VH
`define QEC_ADDR_MODE      6'h00
`define QEC_ADDR_COUNT     6'h04
`define QEC_ADDR_LATCH0    6'h08
`define QEC_ADDR_LATCH1    6'h0C
`define QEC_ADDR_STROBE    6'h10
`define QEC_ADDR_COMPARE   6'h14
`define QEC_ADDR_STATUS    6'h18
`define QEC_ADDR_ENABLE    6'h1C
`define QEC_ADDR_CLEAR     6'h20
`define QEC_ADDR_LOAD      6'h24
`define QEC_ADDR_PINS      6'h28
`define QEC_MODE_RES_LSB   0
`define QEC_MODE_HYST      2
`define QEC_MODE_SPLIT     3
`define QEC_MODE_L0_EXT    4
`define QEC_MODE_L1_EXT    5
`define QEC_MODE_SA_IRQ    6
`define QEC_MODE_SB_IRQ    7
`define QEC_MODE_REF_EN    8
`define QEC_MODE_IDX_EN    9
`define QEC_MODE_OUT       10
`define QEC_MODE_WIDTH     11
`define QEC_MODE_RESET     11'h000
`define QEC_RES_SINGLE     2'h0
`define QEC_RES_DOUBLE     2'h1
`define QEC_RES_QUAD       2'h2
`define QEC_ST_STRB_A      0
`define QEC_ST_STRB_B      1
`define QEC_ST_CMP         2
`define QEC_ST_INDEX       3
`define QEC_ST_FAULT       4
`define QEC_ST_REF         5
`define QEC_ST_ILLEGAL     6
`define QEC_ST_WIDTH       7
`endif

// file: core/qec_decode.v
/*
 Quadrature decoder for one pair of encoder tracks.
 Assumes the track inputs are already synchronised to CLK.
*/
`include "qec_map.vh"
`timescale 1ns/10ps
`default_nettype none
module qec_decode (
	input  wire       CLK,
	input  wire       RST,
	input  wire       trk_a,
	input  wire       trk_b,
	input  wire [1:0] res,
	input  wire       hyst,
	output reg        step,
	output reg        up,
	output reg        illegal
);
	reg  [1:0] prev;
	reg        last_dir;
	reg        have_dir;
	wire [1:0] cur = {trk_a, trk_b};
	wire       chg_a = trk_a ^ prev[1];
	wire       chg_b = trk_b ^ prev[0];
	reg        dir;
	reg        take;

	// Forward when B follows A, derived from the phase relation.
	always @* begin
		dir = chg_a ? (trk_a ^ trk_b) : ~(trk_a ^ trk_b);
		case (res)
		`QEC_RES_SINGLE: take = chg_a & trk_a & ~trk_b | chg_a & ~trk_a & ~trk_b & ~dir;
		`QEC_RES_DOUBLE: take = chg_a;
		default:         take = chg_a | chg_b;
		endcase
		if (chg_a & chg_b) begin
			take = 1'b0;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			prev     <= 2'h0;
			last_dir <= 1'b0;
			have_dir <= 1'b0;
			step     <= 1'b0;
			up       <= 1'b0;
			illegal  <= 1'b0;
		end else begin
			prev    <= cur;
			illegal <= chg_a & chg_b;
			up      <= dir;
			step    <= 1'b0;
			if (take) begin
				have_dir <= 1'b1;
				last_dir <= dir;
				if (!(hyst && have_dir && dir != last_dir)) begin
					step <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: core/qec_top.v
/*
 Quadrature encoder counter with latches, compare, reference and interrupt logic.
 Assumes a classic Wishbone master on CLK and asynchronous field pins.
*/
`include "qec_map.vh"
`timescale 1ns/10ps
`default_nettype none
module qec_top (
	input  wire        CLK,
	input  wire        RST,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [5:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire        TRACK_A,
	input  wire        TRACK_B,
	input  wire        TRACK_C,
	input  wire        TRACK_D,
	input  wire        REF_IN,
	input  wire        CAPTURE_PIN_FIRST,
	input  wire        CAPTURE_PIN_SECOND,
	output reg         GENERAL_OUTPUT,
	output wire        IRQ
);
	reg  [1:0]  s0, s1, s2, s3, s4, s5, s6;
	wire [6:0]  pin_sync = {s6[1], s5[1], s4[1], s3[1], s2[1], s1[1], s0[1]};
	reg  [6:0]  pin_last;
	wire [6:0]  pin_rise = pin_sync & ~pin_last;
	reg  [`QEC_MODE_WIDTH-1:0] mode;
	reg  [31:0] count;
	reg  [31:0] latch0;
	reg  [31:0] latch1;
	reg  [31:0] compare;
	reg  [31:0] load_val;
	reg  [`QEC_ST_WIDTH-1:0] status;
	reg  [`QEC_ST_WIDTH-1:0] irq_en;
	reg  [31:0] next_count;
	reg  [`QEC_ST_WIDTH-1:0] event_set;
	wire        split = mode[`QEC_MODE_SPLIT];
	wire        step0, up0, ill0, step1, up1, ill1;
	wire        wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
	wire        rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O;
	wire        wr_strobe = wr & (WB_ADR_I == `QEC_ADDR_STROBE);
	wire        wr_clear = wr & (WB_ADR_I == `QEC_ADDR_CLEAR);
	wire        wr_load = wr & (WB_ADR_I == `QEC_ADDR_LOAD);
	wire        strb_a = pin_rise[4];
	wire        strb_b = pin_rise[5];
	wire        index_rise = pin_rise[2] & ~split & mode[`QEC_MODE_IDX_EN];
	wire        ref_rise = pin_rise[6] & mode[`QEC_MODE_REF_EN];
	wire        cap0;
	wire        cap1;
	reg  [31:0] merged;
	integer     i;

	// Two flip-flops on every field pin before any logic looks at it.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			s0 <= 2'h0;
			s1 <= 2'h0;
			s2 <= 2'h0;
			s3 <= 2'h0;
			s4 <= 2'h0;
			s5 <= 2'h0;
			s6 <= 2'h0;
			pin_last <= 7'h00;
		end else begin
			s0 <= {s0[0], TRACK_A};
			s1 <= {s1[0], TRACK_B};
			s2 <= {s2[0], TRACK_C};
			s3 <= {s3[0], TRACK_D};
			s4 <= {s4[0], CAPTURE_PIN_FIRST};
			s5 <= {s5[0], CAPTURE_PIN_SECOND};
			s6 <= {s6[0], REF_IN};
			pin_last <= pin_sync;
		end
	end

	qec_decode u_dec0 (
		.CLK     (CLK),
		.RST     (RST),
		.trk_a   (pin_sync[0]),
		.trk_b   (pin_sync[1]),
		.res     (mode[`QEC_MODE_RES_LSB+1:`QEC_MODE_RES_LSB]),
		.hyst    (mode[`QEC_MODE_HYST]),
		.step    (step0),
		.up      (up0),
		.illegal (ill0)
	);

	qec_decode u_dec1 (
		.CLK     (CLK),
		.RST     (RST),
		.trk_a   (pin_sync[2]),
		.trk_b   (pin_sync[3]),
		.res     (mode[`QEC_MODE_RES_LSB+1:`QEC_MODE_RES_LSB]),
		.hyst    (mode[`QEC_MODE_HYST]),
		.step    (step1),
		.up      (up1),
		.illegal (ill1)
	);

	// Strobe routing: an external strobe feeds a latch or the interrupt logic.
	assign cap0 = mode[`QEC_MODE_L0_EXT] ? (strb_a & ~mode[`QEC_MODE_SA_IRQ]) : wr_strobe & WB_DAT_I[0];
	assign cap1 = mode[`QEC_MODE_L1_EXT] ? (strb_b & ~mode[`QEC_MODE_SB_IRQ]) : wr_strobe & WB_DAT_I[1];

	// Counting; split mode keeps two independent 16-bit halves.
	always @* begin
		next_count = count;
		if (split) begin
			if (step0) begin
				next_count[15:0] = up0 ? count[15:0] + 16'h0001 : count[15:0] - 16'h0001;
			end
			if (step1) begin
				next_count[31:16] = up1 ? count[31:16] + 16'h0001 : count[31:16] - 16'h0001;
			end
		end else if (step0) begin
			next_count = up0 ? count + 32'h00000001 : count - 32'h00000001;
		end
		if (index_rise | ref_rise) begin
			next_count = 32'h00000000;
		end
		if (wr_load) begin
			next_count = load_val;
		end
	end

	always @* begin
		event_set = {`QEC_ST_WIDTH{1'b0}};
		event_set[`QEC_ST_STRB_A] = strb_a & mode[`QEC_MODE_SA_IRQ];
		event_set[`QEC_ST_STRB_B] = strb_b & mode[`QEC_MODE_SB_IRQ];
		event_set[`QEC_ST_CMP] = (next_count == compare) & (next_count != count);
		event_set[`QEC_ST_INDEX] = index_rise;
		event_set[`QEC_ST_FAULT] = pin_rise[3] & ~split;
		event_set[`QEC_ST_REF] = ref_rise;
		event_set[`QEC_ST_ILLEGAL] = ill0 | (ill1 & split);
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			mode     <= `QEC_MODE_RESET;
			count    <= 32'h00000000;
			latch0   <= 32'h00000000;
			latch1   <= 32'h00000000;
			compare  <= 32'h00000000;
			load_val <= 32'h00000000;
			status   <= {`QEC_ST_WIDTH{1'b0}};
			irq_en   <= {`QEC_ST_WIDTH{1'b0}};
			GENERAL_OUTPUT <= 1'b0;
		end else begin
			count <= next_count;
			GENERAL_OUTPUT <= mode[`QEC_MODE_OUT];
			if (cap0) begin
				latch0 <= count;
			end
			if (cap1) begin
				latch1 <= count;
			end
			// A set in the same cycle as a clear wins.
			for (i = 0; i < `QEC_ST_WIDTH; i = i + 1) begin
				if (event_set[i] & irq_en[i]) begin
					status[i] <= 1'b1;
				end else if (wr_clear & WB_DAT_I[i]) begin
					status[i] <= 1'b0;
				end
			end
			if (wr) begin
				case (WB_ADR_I)
				`QEC_ADDR_MODE: begin
					mode <= WB_DAT_I[`QEC_MODE_WIDTH-1:0];
				end
				`QEC_ADDR_COMPARE: begin
					compare <= WB_DAT_I;
				end
				`QEC_ADDR_ENABLE: begin
					irq_en <= WB_DAT_I[`QEC_ST_WIDTH-1:0];
				end
				`QEC_ADDR_LOAD: begin
					load_val <= WB_DAT_I;
				end
				default: begin
					irq_en <= irq_en;
				end
				endcase
			end
		end
	end

	always @* begin
		merged = 32'h00000000;
		case (WB_ADR_I)
		`QEC_ADDR_MODE:    merged[`QEC_MODE_WIDTH-1:0] = mode;
		`QEC_ADDR_COUNT:   merged = count;
		`QEC_ADDR_LATCH0:  merged = latch0;
		`QEC_ADDR_LATCH1:  merged = latch1;
		`QEC_ADDR_COMPARE: merged = compare;
		`QEC_ADDR_STATUS:  merged[`QEC_ST_WIDTH-1:0] = status;
		`QEC_ADDR_ENABLE:  merged[`QEC_ST_WIDTH-1:0] = irq_en;
		`QEC_ADDR_PINS:    merged[6:0] = pin_sync;
		default:           merged = 32'h00000000;
		endcase
	end

	// Every access is acknowledged one cycle after it is presented.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
			if (rd) begin
				WB_DAT_O <= merged;
			end
		end
	end

	assign IRQ = |(status & irq_en);
endmodule
`default_nettype wire

// file: test/qec_top_monitor.sv
/* Assertions on the bus, interrupt and output pins of qec_top.
 Bound to qec_top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module qec_top_monitor (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [5:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        GENERAL_OUTPUT,
	input wire logic        IRQ
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (RST);
	wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire logic rd = req && !WB_WE_I;
	wire logic wr = req && WB_WE_I;
	ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	ack_follows_a: assert property (req |=> WB_ACK_O)
		else $error("ack missing");
	data_holds_a: assert property (!rd |=> $stable(WB_DAT_O))
		else $error("read data moved");
	mode_width_a: assert property (rd && WB_ADR_I == 6'h00 |=> !(|WB_DAT_O[31:11]))
		else $error("mode too wide");
	unmapped_zero_a: assert property (rd && WB_ADR_I == 6'h3C |=> WB_DAT_O == 32'h0)
		else $error("unmapped read");
	status_width_a: assert property (rd && WB_ADR_I == 6'h18 |=> !(|WB_DAT_O[31:7]))
		else $error("status too wide");
	irq_masked_a: assert property (wr && WB_ADR_I == 6'h1C && WB_DAT_I == 32'h0 |=> !IRQ)
		else $error("irq while masked");
	out_follows_a: assert property (wr && WB_ADR_I == 6'h00 |=> ##1
		GENERAL_OUTPUT == $past(WB_DAT_I[10], 2)) else $error("output not mode bit");
endmodule
bind qec_top qec_top_monitor mon_u (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .GENERAL_OUTPUT(GENERAL_OUTPUT), .IRQ(IRQ));
`default_nettype wire

// file: test/qec_field_model.sv
/* Field side: one quadrature encoder and the index, fault, reference and strobe pins.
 Moved by the bench through its tasks, on the bench clock. */
`timescale 1ns/10ps
`default_nettype none
module qec_field_model (
	input wire logic  clk,
	output var logic  trk_a,
	output var logic  trk_b,
	output wire logic trk_c,
	output wire logic trk_d,
	output wire logic ref_in,
	output wire logic cap_a,
	output wire logic cap_b
);
	logic [4:0] aux = 5'h00;
	int         ph = 0;
	assign {trk_c, trk_d, ref_in, cap_a, cap_b} = aux;
	initial {trk_a, trk_b} = 2'b00;
	task automatic step(input int d);
		ph = (ph + d) % 4;
		trk_a <= ph == 1 || ph == 2;
		trk_b <= ph > 1;
		repeat (2 + $urandom % 7) @(posedge clk);
	endtask
	task automatic move(input int n);
		repeat (n < 0 ? -n : n) step(n < 0 ? 3 : 1);
		repeat (10) @(posedge clk);
	endtask
	task automatic pulse(input int k);
		aux[k] <= 1'b1;
		repeat (6) @(posedge clk);
		aux[k] <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: test/tb_quadrature_encoder_counter.sv
/* Self-checking bench of qec_top.
 Drives the bus and the field model; checks counts, latches and status. */
`timescale 1ns/10ps
`default_nettype none
module tb_quadrature_encoder_counter;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic [3:0]  sel = 4'hF;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] v;
	wire  [31:0] dout;
	wire         ack, gout, irq, ta, tb, tc, td, rf, ca, cb;
	int          num_errors = 0;
	int          num_checks = 0;
	int          n;
	qec_top dut_u (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.TRACK_A(ta), .TRACK_B(tb), .TRACK_C(tc), .TRACK_D(td), .REF_IN(rf),
		.CAPTURE_PIN_FIRST(ca), .CAPTURE_PIN_SECOND(cb), .GENERAL_OUTPUT(gout), .IRQ(irq));
	qec_field_model fld_u (.clk(clk), .trk_a(ta), .trk_b(tb), .trk_c(tc), .trk_d(td),
		.ref_in(rf), .cap_a(ca), .cap_b(cb));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int t;
		logic seen;
		t = 0;
		seen = 1'b0;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		sel <= $urandom;
		do begin
			@(posedge clk);
			#1;
			seen = ack;
			t++;
		end while (seen !== 1'b1 && t < 20);
		@(posedge clk);
		rdat = dout;
		{cyc, stb, we} <= 3'b000;
		chk(seen, 1'b1);
	endtask
	task automatic look(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic ld(input logic [31:0] d);
		bus(1'b1, 6'h24, d);
		bus(1'b1, 6'h24, d);
	endtask
	function automatic logic [31:0] steps(input int r, input int q);
		return q / 4 * (r == 0 ? 1 : r * 2);
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial forever #12.5 clk = ~clk;
	initial begin
		repeat (50000) @(posedge clk);
		num_errors++;
		results();
	end
	initial begin
		n = $urandom(32'h0d157e27);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		look(6'h00, 32'h0);
		v = $urandom % 2048;
		bus(1'b1, 6'h00, v);
		look(6'h00, v);
		look(6'h3C, 32'h0);
		$display("test registers done");
		for (int r = 0; r < 3; r++) begin
			bus(1'b1, 6'h00, r);
			ld(32'h0);
			n = 4 * (1 + $urandom % 5);
			fld_u.move(n);
			look(6'h04, steps(r, n));
			fld_u.move(-4);
			look(6'h04, steps(r, n - 4));
		end
		bus(1'b1, 6'h00, 32'h6);
		fld_u.move(4);
		ld(32'h0);
		fld_u.move(4);
		look(6'h04, 32'h4);
		fld_u.move(-4);
		look(6'h04, 32'h1);
		$display("test counting done");
		bus(1'b1, 6'h00, 32'h22);
		v = $urandom;
		ld(v);
		bus(1'b1, 6'h10, 32'h3);
		look(6'h08, v);
		look(6'h0C, 32'h0);
		ld(v + 32'h5);
		fld_u.pulse(0);
		look(6'h0C, v + 32'h5);
		bus(1'b1, 6'h00, 32'h42);
		bus(1'b1, 6'h1C, 32'h1);
		ld(32'h9);
		fld_u.pulse(1);
		chk(irq, 1'b1);
		look(6'h08, v);
		bus(1'b1, 6'h1C, 32'h0);
		chk(irq, 1'b0);
		bus(1'b1, 6'h20, 32'h7F);
		look(6'h18, 32'h0);
		$display("test strobes done");
		bus(1'b1, 6'h14, 32'hD);
		bus(1'b1, 6'h1C, 32'h4);
		fld_u.move(8);
		chk(irq, 1'b1);
		bus(1'b1, 6'h20, 32'h4);
		chk(irq, 1'b0);
		bus(1'b1, 6'h00, 32'h302);
		bus(1'b1, 6'h1C, 32'h38);
		ld(32'h5);
		fld_u.pulse(4);
		look(6'h04, 32'h0);
		ld(32'h5);
		fld_u.pulse(2);
		look(6'h04, 32'h0);
		fld_u.pulse(3);
		look(6'h18, 32'h38);
		$display("test events done");
		bus(1'b1, 6'h20, 32'h7F);
		bus(1'b1, 6'h1C, 32'h40);
		ld(32'h3);
		fld_u.step(2);
		fld_u.move(0);
		look(6'h04, 32'h3);
		look(6'h18, 32'h40);
		bus(1'b1, 6'h00, 32'h400);
		@(posedge clk);
		chk(gout, 1'b1);
		$display("test faults done");
		bus(1'b1, 6'h00, 32'hA);
		ld(32'h0);
		fld_u.move(4);
		fld_u.aux[4] <= 1'b1;
		fld_u.move(0);
		look(6'h04, 32'h00010004);
		fld_u.aux[4] <= 1'b0;
		fld_u.move(0);
		look(6'h04, 32'h00000004);
		$display("test split done");
		results();
	end
endmodule
`default_nettype wire
